/* File: rtl/psr_top.sv */
// Processor supervisor: power-fail reset, pushbutton, watchdog and SRAM enable gating
`timescale 1ns/10ps
`default_nettype none
`include "psr_params.svh"

module psr_top
#(
    parameter int TICK_CYCLES = `PSR_TICK_CYCLES,
    parameter int STRETCH_MS = `PSR_STRETCH_MS,
    parameter int WDOG_MS = `PSR_WDOG_MS,
    parameter int DEBOUNCE_MS = `PSR_DEBOUNCE_MS
)
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic power_fail_i,
    input wire logic rst_pin_i,
    output logic rst_pin_o,
    output logic rst_pin_oe_o,
    input wire logic watchdog_strobe_n_i,
    input wire logic ram_enable_in_n_i,
    input wire logic upper_byte_select_n_i,
    input wire logic lower_byte_select_n_i,
    output logic sram_high_byte_enable_n_o,
    output logic sram_low_byte_enable_n_o
);

    psr_pkg::psr_pins_s raw_pins;
    psr_pkg::psr_pins_s pins;
    psr_pkg::psr_ctrl_s st;
    psr_pkg::psr_ctrl_s next_st;
    logic tick;
    logic wdog_fire;
    logic press;
    logic trigger;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    always_comb
    begin
        raw_pins.power_fail = power_fail_i;
        raw_pins.rst_pin = rst_pin_i;
        raw_pins.watchdog_strobe_n = watchdog_strobe_n_i;
        raw_pins.ram_enable_in_n = ram_enable_in_n_i;
        raw_pins.upper_byte_select_n = upper_byte_select_n_i;
        raw_pins.lower_byte_select_n = lower_byte_select_n_i;
    end

    psr_sync u_sync
    (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .pins_i(raw_pins),
        .pins_o(pins)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Millisecond tick and reset causes
    always_comb
    begin
        tick = (st.div == 24'(TICK_CYCLES - 1));
        wdog_fire = (st.state == psr_pkg::PSR_RUN) && tick && pins.watchdog_strobe_n
            && (st.wdog == 8'(WDOG_MS - 1));
        press = (st.state == psr_pkg::PSR_RUN) && tick && !pins.rst_pin
            && (st.debounce == 8'(DEBOUNCE_MS - 1));
        trigger = pins.power_fail || wdog_fire || press;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb
    begin
        next_st = st;
        // Divider restarts on every trigger so the stretch is a whole 250 ticks
        if (trigger || tick)
        begin
            next_st.div = 24'h000000;
        end
        else
        begin
            next_st.div = st.div + 24'h000001;
        end
        unique case (st.state)
            psr_pkg::PSR_RUN:
            begin
                // Watchdog window, restarted by a low strobe
                if (!pins.watchdog_strobe_n)
                begin
                    next_st.wdog = 8'h00;
                end
                else if (tick)
                begin
                    next_st.wdog = st.wdog + 8'h01;
                end
                // Pushbutton debounce: low must hold across DEBOUNCE_MS tick edges
                if (pins.rst_pin)
                begin
                    next_st.debounce = 8'h00;
                end
                else if (tick)
                begin
                    next_st.debounce = st.debounce + 8'h01;
                end
                if (trigger)
                begin
                    next_st.state = psr_pkg::PSR_HOLD;
                    next_st.stretch = 8'(STRETCH_MS);
                    next_st.wdog = 8'h00;
                    next_st.debounce = 8'h00;
                end
            end
            psr_pkg::PSR_HOLD:
            begin
                next_st.wdog = 8'h00;
                next_st.debounce = 8'h00;
                if (trigger)
                begin
                    next_st.stretch = 8'(STRETCH_MS);
                end
                else if (tick)
                begin
                    next_st.stretch = st.stretch - 8'h01;
                    if (st.stretch == 8'h01)
                    begin
                        next_st.state = psr_pkg::PSR_RUN;
                    end
                end
            end
        endcase
        // Reset pin pulled low while holding or on a fresh cause
        next_st.rst_oe = (next_st.state == psr_pkg::PSR_HOLD);
        // Byte enables follow the selects, gated off during power fail
        next_st.sram_high_byte_enable_n = pins.power_fail || pins.ram_enable_in_n
            || pins.upper_byte_select_n;
        next_st.sram_low_byte_enable_n = pins.power_fail || pins.ram_enable_in_n
            || pins.lower_byte_select_n;
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register; power-up starts with a full stretched reset
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            st.state <= psr_pkg::PSR_HOLD;
            st.div <= 24'h000000;
            st.stretch <= 8'(STRETCH_MS);
            st.wdog <= 8'h00;
            st.debounce <= 8'h00;
            st.rst_oe <= 1'b1;
            st.sram_high_byte_enable_n <= 1'b1;
            st.sram_low_byte_enable_n <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    // Outputs straight from flip-flops; the pin only ever drives low
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            rst_pin_o <= 1'b0;
        end
        else
        begin
            rst_pin_o <= 1'b0;
        end
    end

    assign rst_pin_oe_o = st.rst_oe;
    assign sram_high_byte_enable_n_o = st.sram_high_byte_enable_n;
    assign sram_low_byte_enable_n_o = st.sram_low_byte_enable_n;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    AST_PF_RESET: assert property (@(posedge clk_i) disable iff (reset_i)
        pins.power_fail |=> rst_pin_oe_o)
        else $error("reset not driven during power fail");

    AST_PF_STRETCH: assert property (@(posedge clk_i) disable iff (reset_i)
        $fell(pins.power_fail) |-> rst_pin_oe_o [*8] ##1 (st.stretch != 8'h00))
        else $error("reset released early after power fail");

    AST_PRESS_RESET: assert property (@(posedge clk_i) disable iff (reset_i)
        press |=> rst_pin_oe_o && (st.stretch == 8'(STRETCH_MS)))
        else $error("pushbutton did not start a full reset");

    AST_WDOG_RESET: assert property (@(posedge clk_i) disable iff (reset_i)
        wdog_fire |=> rst_pin_oe_o && (st.state == psr_pkg::PSR_HOLD))
        else $error("watchdog timeout did not force reset");

    AST_SRAM_GATE: assert property (@(posedge clk_i) disable iff (reset_i)
        pins.power_fail |=> sram_high_byte_enable_n_o && sram_low_byte_enable_n_o)
        else $error("SRAM enable active during power fail");

    AST_PIN_DRIVE: assert property (@(posedge clk_i) disable iff (reset_i)
        (rst_pin_oe_o == (st.state == psr_pkg::PSR_HOLD)) && !rst_pin_o)
        else $error("reset pin drive does not match hold state");

    AST_BYTE_ENABLE: assert property (@(posedge clk_i) disable iff (reset_i)
        !pins.power_fail && !pins.ram_enable_in_n |=>
        (sram_high_byte_enable_n_o == $past(pins.upper_byte_select_n))
        && (sram_low_byte_enable_n_o == $past(pins.lower_byte_select_n)))
        else $error("SRAM byte enable does not follow selects");

    AST_WDOG_RESTART: assert property (@(posedge clk_i) disable iff (reset_i)
        (st.state == psr_pkg::PSR_RUN) && !pins.watchdog_strobe_n |=> (st.wdog == 8'h00) && !wdog_fire)
        else $error("strobe did not restart watchdog");

    AST_WDOG_CLEARED: assert property (@(posedge clk_i) disable iff (reset_i)
        (st.state == psr_pkg::PSR_HOLD) |=> (st.wdog == 8'h00))
        else $error("watchdog counted during reset");

endmodule // psr_top

`default_nettype wire

/* File: rtl/psr_params.svh */
// Constants for the processor supervisor reset block
// Functional notes
// - Processor reset is driven low whenever the supply monitor flags a power fail.
// - Once the power fail clears, reset is held for another 250 ms before release.
// - A debounced low on the reset pin gives a processor reset of at least 250 ms.
// - The processor must pull the strobe low in time, otherwise reset is forced.
// - While power is failing, both SRAM chip enables are held inactive.
// - The reset pin is open drain, driven low by the block and also sampled as a pushbutton.
// - Each SRAM byte enable goes low only while the RAM enable and its byte select are both low.
// - Every low strobe restarts the watchdog, which fires on the 150th tick edge with no low strobe.
`ifndef PSR_PARAMS_SVH
`define PSR_PARAMS_SVH

// Timing base
`define PSR_CLK_PERIOD_NS 40
`define PSR_TICK_NS 1000000
`define PSR_TICK_CYCLES (`PSR_TICK_NS / `PSR_CLK_PERIOD_NS)

// Times in milliseconds, counted in ticks
`define PSR_STRETCH_MS 250
`define PSR_WDOG_MS 150
`define PSR_DEBOUNCE_MS 10

// Reset value of the sampled pins: power fail flagged, all others high
`define PSR_PINS_RST 6'h3F

`endif

/* File: rtl/psr_pkg.sv */
// Types shared by the processor supervisor reset block
`default_nettype none
package psr_pkg;

    // Controller states, one-hot
    typedef enum logic [1:0] {
        PSR_RUN = 2'b01,
        PSR_HOLD = 2'b10
    } psr_state_e;

    // Inputs that arrive from outside the clock domain
    typedef struct packed {
        logic power_fail;
        logic rst_pin;
        logic watchdog_strobe_n;
        logic ram_enable_in_n;
        logic upper_byte_select_n;
        logic lower_byte_select_n;
    } psr_pins_s;

    // Synchroniser state
    typedef struct packed {
        psr_pins_s ff1;
        psr_pins_s ff2;
        psr_pins_s ff3;
        psr_pins_s agreed;
    } psr_sync_s;

    // Controller state
    typedef struct packed {
        psr_state_e state;
        logic [23:0] div;
        logic [7:0] stretch;
        logic [7:0] wdog;
        logic [7:0] debounce;
        logic rst_oe;
        logic sram_high_byte_enable_n;
        logic sram_low_byte_enable_n;
    } psr_ctrl_s;

endpackage

`default_nettype wire

/* File: rtl/psr_sync.sv */
// Three-stage synchroniser whose output follows once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
`include "psr_params.svh"

module psr_sync
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire psr_pkg::psr_pins_s pins_i,
    output var psr_pkg::psr_pins_s pins_o
);

    psr_pkg::psr_sync_s st;
    psr_pkg::psr_sync_s next_st;

    ////////////////////////////////////////////////////////////////////////////
    // Shift chain; agreed value moves only where stages two and three match
    always_comb
    begin
        next_st = st;
        next_st.ff1 = pins_i;
        next_st.ff2 = st.ff1;
        next_st.ff3 = st.ff2;
        next_st.agreed = (st.ff2 & st.ff3) | (st.agreed & (st.ff2 | st.ff3));
    end

    // State register
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            st <= {4{`PSR_PINS_RST}};
        end
        else
        begin
            st <= next_st;
        end
    end

    assign pins_o = st.agreed;

endmodule // psr_sync

`default_nettype wire

/* File: verif/psr_host.sv */
// Host processor model: takes the reset wire and strobes the watchdog
`timescale 1ns/10ps
`default_nettype none

module psr_host
#(
    parameter int PERIOD = 1000
)
(
    input wire logic clk_i,
    input wire logic rst_wire_i,
    input wire logic strobe_en_i,
    output var logic watchdog_strobe_n_o
);
    int cnt = 0;

    initial watchdog_strobe_n_o = 1'b1;

    // Strobe low for four cycles every PERIOD cycles, only while out of reset
    // Updated on the edge itself so the bench reads a settled strobe
    always @(posedge clk_i)
    begin
        if (!rst_wire_i || !strobe_en_i)
        begin
            cnt <= 0;
            watchdog_strobe_n_o <= 1'b1;
        end
        else
        begin
            cnt <= cnt + 1;
            watchdog_strobe_n_o <= !(((cnt + 1) % PERIOD) < 4);
        end
    end
endmodule // psr_host

`default_nettype wire

/* File: verif/testbench.sv */
// Self-checking bench for the processor supervisor reset block
`timescale 1ns/10ps
`default_nettype none

module testbench;
    localparam int TK = 10;
    localparam int STR = 250 * TK;
    localparam int WD = 150 * TK;
    localparam int DB = 10 * TK;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic pf = 1'b0;
    logic button = 1'b0;
    logic ram_n = 1'b1;
    logic up_n = 1'b1;
    logic lo_n = 1'b1;
    logic strobe_en = 1'b1;
    logic pin_o, pin_oe, hi_n, lo_en_n, strobe_n, pin;
    int n_errors = 0;
    int num_checks = 0;
    int n;

    // Open-drain wire: pulled up unless the block or the button pulls it low
    assign pin = (pin_oe !== 1'b0 || button) ? 1'b0 : 1'b1;

    psr_top #(.TICK_CYCLES(TK)) dut (.clk_i(clk), .reset_i(reset), .power_fail_i(pf), .rst_pin_i(pin),
        .rst_pin_o(pin_o), .rst_pin_oe_o(pin_oe), .watchdog_strobe_n_i(strobe_n),
        .ram_enable_in_n_i(ram_n), .upper_byte_select_n_i(up_n), .lower_byte_select_n_i(lo_n),
        .sram_high_byte_enable_n_o(hi_n), .sram_low_byte_enable_n_o(lo_en_n));

    psr_host host (.clk_i(clk), .rst_wire_i(pin), .strobe_en_i(strobe_en), .watchdog_strobe_n_o(strobe_n));

    initial
    begin
        forever #20 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    // Wait until the reset drive reaches v; cycles taken land in n
    task automatic wait_oe(input logic v, input int lim);
        n = 0;
        while (pin_oe !== v)
        begin
            if (n == lim)
            begin
                check(32'(pin_oe), 32'(v));
                final_report();
            end
            cyc(1);
            n++;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_powerup();
        wait_oe(1'b0, STR + 40);
        check(32'(n >= STR && n <= STR + 10), 32'h1);
        $display("test powerup done");
    endtask

    task automatic t_pfail();
        {ram_n, up_n, lo_n} = 3'h0;
        cyc(10);
        check(32'({hi_n, lo_en_n}), 32'h0);
        pf = 1'b1;
        cyc(8);
        check(32'(pin_oe), 32'h1);
        check(32'({hi_n, lo_en_n}), 32'h3);
        cyc(50);
        pf = 1'b0;
        cyc(10);
        check(32'({hi_n, lo_en_n}), 32'h0);
        wait_oe(1'b0, STR + 40);
        check(32'(n + 10 >= STR && n + 10 <= STR + 10), 32'h1);
        $display("test pfail done");
    endtask

    task automatic t_enables();
        for (int i = 0; i < 8; i++)
        begin
            {ram_n, up_n, lo_n} = 3'(i);
            cyc(8);
            check(32'({hi_n, lo_en_n}), 32'({ram_n | up_n, ram_n | lo_n}));
        end
        $display("test enables done");
    endtask

    task automatic t_watchdog();
        n = 0;
        repeat (5000)
        begin
            cyc(1);
            n += int'(pin_oe !== 1'b0);
        end
        check(n, 32'h0);
        for (n = 0; n < 1100 && strobe_n !== 1'b0; n++)
            cyc(1);
        check(32'(strobe_n), 32'h0);
        if (n == 1100)
            final_report();
        cyc(4);
        strobe_en = 1'b0;
        wait_oe(1'b1, WD + 100);
        check(32'(n >= WD - TK && n <= WD + 10), 32'h1);
        strobe_en = 1'b1;
        wait_oe(1'b0, STR + 40);
        check(32'(n >= STR - 5 && n <= STR + 10), 32'h1);
        $display("test watchdog done");
    endtask

    task automatic t_button();
        button = 1'b1;
        cyc(DB / 2);
        button = 1'b0;
        cyc(200);
        check(32'(pin_oe), 32'h0);
        button = 1'b1;
        wait_oe(1'b1, DB + 40);
        check(32'(n >= DB - TK && n <= DB + 10), 32'h1);
        check(32'(pin_o), 32'h0);
        cyc(20);
        button = 1'b0;
        wait_oe(1'b0, STR + 40);
        check(32'(n + 20 >= STR && n + 20 <= STR + 20), 32'h1);
        $display("test button done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence: reset, then each scenario in turn
    initial
    begin
        repeat (6) @(posedge clk);
        #1;
        check(32'({pin_oe, hi_n, lo_en_n}), 32'h7);
        reset = 1'b0;
        t_powerup();
        t_pfail();
        t_enables();
        t_watchdog();
        t_button();
        final_report();
    end
endmodule // testbench

`default_nettype wire
